// [core/gtc_params.svh]
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH

`define GTC_ADDR_CTRL      4'h0
`define GTC_ADDR_CNT_LO    4'h1
`define GTC_ADDR_CNT_HI    4'h2
`define GTC_ADDR_FLAGS     4'h3
`define GTC_ADDR_IRQ_EN    4'h4
`define GTC_ADDR_CMP_CTRL  4'h5

`define GTC_CTRL_RESET     8'h00
`define GTC_BIT_ON         0
`define GTC_BIT_CS         1
`define GTC_BIT_SYNC       2
`define GTC_BIT_OSCEN      3
`define GTC_BIT_PS_LO      4
`define GTC_BIT_PS_HI      5
`define GTC_BIT_GE         6
`define GTC_BIT_GINV       7
`define GTC_BIT_GSS        1
`define GTC_BIT_PERIPHERAL_IRQ_ENABLE       1
`define GTC_BIT_GIE        2

`define GTC_CYC_PER_INSTR  2'h3

`endif

// [core/gtc_pkg.sv]
package gtc_pkg;
    typedef enum logic [1:0] {GTC_WAIT_LOW, GTC_ARMED} gtc_arm_t;
    typedef logic [15:0] gtc_count_t;
endpackage : gtc_pkg

// [core/gtc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module gtc_sync (
    input  wire logic clk_sys,   // system clock
    input  wire logic rstn,      // sync reset, active low
    input  wire logic ce,        // clock enable
    input  wire logic d_async,   // pin level
    output logic      q_sync     // synchronized level
);
    logic meta_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            meta_ff <= 1'b0;
            q_sync  <= 1'b0;
        end else if (ce) begin
            meta_ff <= d_async;
            q_sync  <= meta_ff;
        end
    end
endmodule : gtc_sync
`default_nettype wire

// [core/gtc_timer.sv]
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_params.svh"
module gtc_timer (
    input  wire logic       clk_sys,          // system clock, 20 MHz
    input  wire logic       rstn,             // sync reset, active low
    input  wire logic       ce,               // clock enable, freezes all state
    input  wire logic [3:0] addr,             // register address
    input  wire logic [7:0] wdata,            // write data
    input  wire logic       wr,               // write strobe
    input  wire logic       rd,               // read strobe
    output logic      [7:0] rdata,            // read data, cycle after rd
    input  wire logic       count_input_pin,  // external count pin
    input  wire logic       lp_osc_clk,       // low-power oscillator output
    input  wire logic       gate_pin,         // gate pin
    input  wire logic       comparator_output,// comparator output
    input  wire logic       sleep,            // device asleep
    input  wire logic       internal_oscillator_no_clkout, // internal osc without clock out
    input  wire logic       special_event,    // trigger pulse from compare unit
    output logic            irq,              // interrupt request
    output logic            wake,             // wake-up from sleep pulse
    output logic            cmp_sync_clk,     // count clock for comparator sync
    output logic            lp_osc_on         // low-power oscillator enable
);
    logic [7:0]          timer_control_ff;
    logic                gate_source_select_ff;
    logic                overflow_flag_ff;
    logic                overflow_irq_enable_ff;
    logic                peripheral_irq_enable_ff;
    logic                global_irq_enable_ff;
    gtc_pkg::gtc_count_t count_ff;
    gtc_pkg::gtc_count_t nxt_count;
    logic [2:0]          presc_ff;
    logic [1:0]          instr_div_ff;
    gtc_pkg::gtc_arm_t   arm_ff;
    logic                ext_prev_ff;
    logic                src_prev_ff;
    logic [7:0]          nxt_rdata;

    logic pin_s;
    logic gate_pin_s;
    logic cmp_s;
    logic osc_s;
    logic ext_level;
    logic instr_tick;
    logic ext_rise;
    logic src_tick;
    logic gate_lvl;
    logic gate_ok;
    logic run;
    logic presc_done;
    logic inc;
    logic wr_lo;
    logic wr_hi;
    logic asleep_block;

    gtc_sync u_sync_pin (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d_async (count_input_pin),
        .q_sync  (pin_s)
    );
    gtc_sync u_sync_gate (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d_async (gate_pin),
        .q_sync  (gate_pin_s)
    );
    gtc_sync u_sync_cmp (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d_async (comparator_output),
        .q_sync  (cmp_s)
    );
    gtc_sync u_sync_osc (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .d_async (lp_osc_clk),
        .q_sync  (osc_s)
    );

    wire on_bit   = timer_control_ff[`GTC_BIT_ON];
    wire ext_sel  = timer_control_ff[`GTC_BIT_CS];
    wire bypass   = timer_control_ff[`GTC_BIT_SYNC];
    wire osc_en   = timer_control_ff[`GTC_BIT_OSCEN] & internal_oscillator_no_clkout;
    wire [1:0] ps = timer_control_ff[`GTC_BIT_PS_HI:`GTC_BIT_PS_LO];

    assign wr_lo = wr && (addr == `GTC_ADDR_CNT_LO);
    assign wr_hi = wr && (addr == `GTC_ADDR_CNT_HI);

    // external level: oscillator when enabled, else count pin
    assign ext_level  = osc_en ? osc_s : pin_s;
    assign instr_tick = (instr_div_ff == `GTC_CYC_PER_INSTR);
    assign ext_rise   = ext_level && !ext_prev_ff && (arm_ff == gtc_pkg::GTC_ARMED);
    assign src_tick   = ext_sel ? ext_rise : instr_tick;

    // only unsynchronized external counting survives sleep; bypass keeps
    // counting on the sampled edge, modelling the free-running path
    assign asleep_block = sleep && !(ext_sel && bypass);

    assign gate_lvl = gate_source_select_ff ? cmp_s : gate_pin_s;
    assign gate_ok  = timer_control_ff[`GTC_BIT_GINV] ? gate_lvl : !gate_lvl;
    assign run      = on_bit && (!timer_control_ff[`GTC_BIT_GE] || gate_ok);

    always_comb begin
        presc_done = 1'b0;
        unique case (ps)
            2'b00: presc_done = 1'b1;
            2'b01: presc_done = presc_ff[0];
            2'b10: presc_done = &presc_ff[1:0];
            2'b11: presc_done = &presc_ff;
        endcase
    end

    assign inc = run && src_tick && !asleep_block && presc_done;

    always_comb begin
        nxt_count = count_ff;
        if (special_event) begin
            nxt_count = 16'h0000;
        end else if (inc) begin
            nxt_count = count_ff + 16'h0001;
        end
        if (wr_lo) begin
            nxt_count[7:0] = wdata;
        end
        if (wr_hi) begin
            nxt_count[15:8] = wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_ff <= 16'h0000;
        end else if (ce) begin
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            presc_ff <= 3'h0;
        end else if (ce) begin
            if (wr_lo || wr_hi) begin
                presc_ff <= 3'h0;
            end else if (run && src_tick && !asleep_block) begin
                presc_ff <= presc_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            instr_div_ff <= 2'h0;
        end else if (ce) begin
            instr_div_ff <= instr_div_ff + 2'h1;
        end
    end

    // low level must be seen after enabling before counting rises
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            arm_ff      <= gtc_pkg::GTC_WAIT_LOW;
            ext_prev_ff <= 1'b0;
        end else if (ce) begin
            ext_prev_ff <= ext_level;
            if (!on_bit || !ext_sel) begin
                arm_ff <= gtc_pkg::GTC_WAIT_LOW;
            end else begin
                unique case (arm_ff)
                    gtc_pkg::GTC_WAIT_LOW: begin
                        if (!ext_level) begin
                            arm_ff <= gtc_pkg::GTC_ARMED;
                        end
                    end
                    gtc_pkg::GTC_ARMED: arm_ff <= gtc_pkg::GTC_ARMED;
                    default: arm_ff <= gtc_pkg::GTC_WAIT_LOW;
                endcase
            end
        end
    end

    // overflow only from an increment, set even when a same-cycle trigger clear overrides it
    wire ovf = inc && (count_ff == 16'hFFFF) && !wr_lo && !wr_hi;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            overflow_flag_ff <= 1'b0;
        end else if (ce) begin
            if (ovf) begin
                overflow_flag_ff <= 1'b1;
            end else if (wr && addr == `GTC_ADDR_FLAGS && !wdata[0]) begin
                overflow_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            timer_control_ff         <= `GTC_CTRL_RESET;
            gate_source_select_ff    <= 1'b0;
            overflow_irq_enable_ff   <= 1'b0;
            peripheral_irq_enable_ff <= 1'b0;
            global_irq_enable_ff     <= 1'b0;
        end else if (ce && wr) begin
            if (addr == `GTC_ADDR_CTRL) begin
                timer_control_ff <= wdata;
            end
            if (addr == `GTC_ADDR_CMP_CTRL) begin
                gate_source_select_ff <= wdata[`GTC_BIT_GSS];
            end
            if (addr == `GTC_ADDR_IRQ_EN) begin
                overflow_irq_enable_ff   <= wdata[0];
                peripheral_irq_enable_ff <= wdata[`GTC_BIT_PERIPHERAL_IRQ_ENABLE];
                global_irq_enable_ff     <= wdata[`GTC_BIT_GIE];
            end
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                `GTC_ADDR_CTRL:     nxt_rdata = timer_control_ff;
                `GTC_ADDR_CNT_LO:   nxt_rdata = count_ff[7:0];
                `GTC_ADDR_CNT_HI:   nxt_rdata = count_ff[15:8];
                `GTC_ADDR_FLAGS:    nxt_rdata = {7'h00, overflow_flag_ff};
                `GTC_ADDR_IRQ_EN:   nxt_rdata = {5'h00, global_irq_enable_ff,
                                                 peripheral_irq_enable_ff,
                                                 overflow_irq_enable_ff};
                `GTC_ADDR_CMP_CTRL: nxt_rdata = {6'h00, gate_source_select_ff, 1'b0};
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata        <= 8'h00;
            irq          <= 1'b0;
            wake         <= 1'b0;
            cmp_sync_clk <= 1'b0;
            lp_osc_on    <= 1'b0;
            src_prev_ff  <= 1'b0;
        end else if (ce) begin
            rdata        <= nxt_rdata;
            irq          <= overflow_flag_ff && overflow_irq_enable_ff
                            && peripheral_irq_enable_ff && global_irq_enable_ff;
            wake         <= sleep && ovf && on_bit && overflow_irq_enable_ff
                            && peripheral_irq_enable_ff;
            src_prev_ff  <= src_tick;
            cmp_sync_clk <= src_tick && !src_prev_ff;
            lp_osc_on    <= osc_en;
        end
    end
endmodule : gtc_timer
`default_nettype wire

// [tb/gtc_ext_src.sv]
`timescale 1ns/1ns
`default_nettype none
module gtc_ext_src (
    input  wire logic run,  // produce pulses
    output logic      pin   // count input level
);
    // four system clocks per period, low outside bursts
    initial pin = 1'b0;
    always #100 pin = run ? ~pin : 1'b0;
endmodule : gtc_ext_src
`default_nettype wire

// [tb/gtc_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module gtc_monitor (
    input wire logic       clk_sys,          // clock
    input wire logic       rstn,             // reset
    input wire logic       ce,               // enable
    input wire logic [3:0] addr,             // address
    input wire logic [7:0] wdata,            // write data
    input wire logic       wr,               // write
    input wire logic       rd,               // read
    input wire logic [7:0] rdata,            // read data
    input wire logic       sleep,            // asleep
    input wire logic       internal_oscillator_no_clkout, // osc mode
    input wire logic       irq,              // interrupt
    input wire logic       wake,             // wake pulse
    input wire logic       lp_osc_on         // osc enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_ctrl_wr_rd;
        (wr && addr == 4'h0) ##1 !wr ##1 (rd && addr == 4'h0);
    endsequence
    sequence s_mask_wr;
        (wr && addr == 4'h4 && wdata[2:0] != 3'h7) ##1 !(wr && addr == 4'h4);
    endsequence
    a_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (rd && addr > 4'h5 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_echo: assert property (s_ctrl_wr_rd |=> rdata == $past(wdata, 3))
        else $error("control readback wrong");
    a_irq_masked: assert property (s_mask_wr |=> !irq)
        else $error("irq while masked");
    a_osc_mode: assert property (!internal_oscillator_no_clkout |=> !lp_osc_on)
        else $error("osc on in wrong mode");
    a_wake_sleep: assert property (wake |-> $past(sleep))
        else $error("wake while awake");
    a_wake_single: assert property (wake |=> !wake)
        else $error("wake too long");
    a_reset_quiet: assert property ($rose(rstn) |-> !irq && !wake && !lp_osc_on)
        else $error("output set after reset");
endmodule : gtc_monitor
bind gtc_timer gtc_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep),
    .internal_oscillator_no_clkout(internal_oscillator_no_clkout), .irq(irq), .wake(wake), .lp_osc_on(lp_osc_on));
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk_sys, rstn, ce, wr, rd, run, gate_pin, comparator_output;
    logic        sleep, internal_oscillator_no_clkout, special_event, irq, wake, cmp_sync_clk, lp_osc_on;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, v;
    logic [15:0] cnt;
    wire         count_input_pin;
    int          comparisons, miscompares;
    gtc_ext_src ext (.run(run), .pin(count_input_pin));
    gtc_timer uut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .count_input_pin(count_input_pin),
        .lp_osc_clk(1'b0), .gate_pin(gate_pin), .comparator_output(comparator_output),
        .sleep(sleep), .internal_oscillator_no_clkout(internal_oscillator_no_clkout), .special_event(special_event),
        .irq(irq), .wake(wake), .cmp_sync_clk(cmp_sync_clk), .lp_osc_on(lp_osc_on));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic rd_cnt();
        rd_reg(4'h1);
        cnt[7:0] = v;
        rd_reg(4'h2);
        cnt[15:8] = v;
    endtask : rd_cnt
    // clear count, run with control c for n cycles, stop, read back
    task automatic run_for(input logic [7:0] c, input int n);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h1, 8'h00);
        wr_reg(4'h0, c);
        repeat (n) @(posedge clk_sys);
        wr_reg(4'h0, 8'h00);
        rd_cnt();
    endtask : run_for
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic t_reset();
        rd_reg(4'h0);
        chk(v, 8'h00);
        rd_reg(4'h3);
        chk(v, 8'h00);
        rd_reg(4'hF);
        chk(v, 8'h00);
        internal_oscillator_no_clkout <= 1'b1;
        wr_reg(4'h0, 8'hF8);
        rd_reg(4'h0);
        chk(v, 8'hF8);
        chk(lp_osc_on, 1'b1);
        internal_oscillator_no_clkout <= 1'b0;
        rd_reg(4'h0);
        chk(lp_osc_on, 1'b0);
        wr_reg(4'h0, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_prescale();
        int pulses;
        pulses = 0;
        for (int p = 0; p < 4; p++) begin
            run_for({2'b00, p[1:0], 4'h1}, 256 << p);
            chk(cnt >= 16'd63 && cnt <= 16'd65, 1'b1);
        end
        v = cnt[7:0];
        // instruction clock ticks once every four cycles, timer on or off
        repeat (40) begin
            @(posedge clk_sys);
            #1 if (cmp_sync_clk === 1'b1) pulses++;
        end
        chk(pulses[15:0], 16'd10);
        rd_reg(4'h1);
        chk(v, cnt[7:0]);
        $display("prescale test done");
    endtask : t_prescale
    task automatic t_overflow();
        wr_reg(4'h2, 8'hFF);
        wr_reg(4'h1, 8'hFE);
        wr_reg(4'h0, 8'h01);
        repeat (20) @(posedge clk_sys);
        wr_reg(4'h0, 8'h00);
        rd_cnt();
        chk(cnt[15:8], 8'h00);
        rd_reg(4'h3);
        chk(v[0], 1'b1);
        wr_reg(4'h4, 8'h07);
        rd_reg(4'h0);
        chk(irq, 1'b1);
        wr_reg(4'h4, 8'h03);
        rd_reg(4'h0);
        chk(irq, 1'b0);
        wr_reg(4'h4, 8'h07);
        wr_reg(4'h3, 8'h00);
        rd_reg(4'h3);
        chk({v[0], irq}, 2'b00);
        wr_reg(4'h4, 8'h00);
        $display("overflow test done");
    endtask : t_overflow
    task automatic t_trigger();
        wr_reg(4'h2, 8'h12);
        wr_reg(4'h1, 8'h34);
        @(posedge clk_sys);
        special_event <= 1'b1;
        @(posedge clk_sys);
        special_event <= 1'b0;
        rd_cnt();
        chk(cnt, 16'h0000);
        rd_reg(4'h3);
        chk(v[0], 1'b0);
        @(posedge clk_sys);
        addr <= 4'h1;
        wdata <= 8'h55;
        wr <= 1'b1;
        special_event <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        special_event <= 1'b0;
        rd_reg(4'h1);
        chk(v, 8'h55);
        $display("trigger test done");
    endtask : t_trigger
    task automatic t_gate();
        gate_pin <= 1'b1;
        run_for(8'h01, 64);
        chk(cnt >= 16'd15 && cnt <= 16'd17, 1'b1);
        run_for(8'h41, 64);
        chk(cnt, 16'h0000);
        run_for(8'hC1, 64);
        chk(cnt >= 16'd15 && cnt <= 16'd17, 1'b1);
        wr_reg(4'h5, 8'h02);
        comparator_output <= 1'b0;
        run_for(8'hC1, 64);
        chk(cnt, 16'h0000);
        comparator_output <= 1'b1;
        run_for(8'hC1, 64);
        chk(cnt >= 16'd15 && cnt <= 16'd17, 1'b1);
        wr_reg(4'h5, 8'h00);
        $display("gate test done");
    endtask : t_gate
    task automatic t_sleep();
        logic seen;
        seen = 1'b0;
        sleep <= 1'b1;
        run_for(8'h01, 64);
        chk(cnt, 16'h0000);
        wr_reg(4'h2, 8'hFF);
        wr_reg(4'h1, 8'hFE);
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h4, 8'h03);
        run <= 1'b1;
        wr_reg(4'h0, 8'h07);
        for (int i = 0; i < 400 && !seen; i++) begin
            @(posedge clk_sys);
            #1 if (wake === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
        if (!seen) report_and_stop();
        run <= 1'b0;
        sleep <= 1'b0;
        wr_reg(4'h0, 8'h00);
        $display("sleep test done");
    endtask : t_sleep
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        {wr, rd, addr, wdata, run, gate_pin, comparator_output} = '0;
        {sleep, internal_oscillator_no_clkout, special_event} = '0;
        comparisons = 0;
        miscompares = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_prescale();
        t_overflow();
        t_trigger();
        t_gate();
        t_sleep();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
